/* src/fnr_async_fifo.sv */
/*
 * Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
 * Assumes DEPTH is a power of two, at least 2; the write side clears
 * synchronously, the read side asynchronously.
 */
`timescale 1ns/100ps
`default_nettype none
module fnr_async_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic wr_clk,
	input wire logic wr_srst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_clk,
	input wire logic rd_arst,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_XOR = {2'b11, {(AW-1){1'b0}}};

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wbin_ff, wgray_ff, rg_s1_ff, rg_s2_ff;
	logic [AW:0] rbin_ff, rgray_ff, wg_s1_ff, wg_s2_ff;
	logic [AW:0] nxt_wbin, nxt_rbin;
	logic push, pop;

	// Write side: full when pointers differ only in their two top bits
	always_comb begin
		wr_ready = (wgray_ff ^ rg_s2_ff) != FULL_XOR;
		push = wr_valid & wr_ready;
		nxt_wbin = wbin_ff + (AW+1)'(push);
	end

	always_ff @(posedge wr_clk) begin
		if (wr_srst) begin
			wbin_ff <= '0;
			wgray_ff <= '0;
			rg_s1_ff <= '0;
			rg_s2_ff <= '0;
		end else begin
			wbin_ff <= nxt_wbin;
			wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
			rg_s1_ff <= rgray_ff;
			rg_s2_ff <= rg_s1_ff;
		end
	end

	// Storage, written only on an accepted word
	always_ff @(posedge wr_clk) begin
		if (push) begin
			mem_ff[wbin_ff[AW-1:0]] <= wr_data;
		end
	end

	// Read side: empty when the synced write pointer equals ours
	always_comb begin
		rd_valid = rgray_ff != wg_s2_ff;
		pop = rd_valid & rd_ready;
		nxt_rbin = rbin_ff + (AW+1)'(pop);
		rd_data = mem_ff[rbin_ff[AW-1:0]];
	end

	always_ff @(posedge rd_clk or posedge rd_arst) begin
		if (rd_arst) begin
			rbin_ff <= '0;
			rgray_ff <= '0;
			wg_s1_ff <= '0;
			wg_s2_ff <= '0;
		end else begin
			rbin_ff <= nxt_rbin;
			rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
			wg_s1_ff <= wgray_ff;
			wg_s2_ff <= wg_s1_ff;
		end
	end
endmodule
`default_nettype wire

/* src/fnr_pkg.sv */
/*
 * Shared constants and types of the multi-lane fast-read output path:
 * opcodes, page-buffer geometry, dummy-clock counts and the carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fnr_pkg;
	// Read opcodes handled by this path
	localparam logic [7:0] OPC_DUAL_OUT_4B = 8'h3c;
	localparam logic [7:0] OPC_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OPC_QUAD_OUT_4B = 8'h6c;
	localparam logic [7:0] OPC_DUAL_IO = 8'hbb;
	localparam logic [7:0] OPC_DUAL_IO_4B = 8'hbc;
	localparam logic [7:0] OPC_QUAD_IO = 8'heb;
	localparam logic [7:0] OPC_QUAD_IO_4B = 8'hec;

	// Page buffer geometry
	localparam int FNR_BUF_BYTES = 32'h840;
	localparam int FNR_BUF_AW = 32'hc;
	localparam int FNR_FIFO_DEPTH = 32'h4;
	localparam logic [15:0] FNR_COL_ZERO = 16'h0000;

	// Lane counts of a phase
	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;

	// Last clock index of the 16-bit column phase per input lane count, and of the opcode phase
	localparam logic [5:0] ADDR_LAST_1 = 6'h0f;
	localparam logic [5:0] ADDR_LAST_2 = 6'h07;
	localparam logic [5:0] ADDR_LAST_4 = 6'h03;
	localparam logic [5:0] OPC_LAST = 6'h07;

	// Dummy clocks: S/D/Q address lanes, 3B/4B form, B1/B0 buffer mode
	localparam logic [5:0] DMY_S_3B_B1 = 6'h08;
	localparam logic [5:0] DMY_S_3B_B0 = 6'h20;
	localparam logic [5:0] DMY_S_4B_B1 = 6'h18;
	localparam logic [5:0] DMY_S_4B_B0 = 6'h28;
	localparam logic [5:0] DMY_D_3B_B1 = 6'h04;
	localparam logic [5:0] DMY_D_3B_B0 = 6'h10;
	localparam logic [5:0] DMY_D_4B_B1 = 6'h0c;
	localparam logic [5:0] DMY_D_4B_B0 = 6'h14;
	localparam logic [5:0] DMY_Q_3B_B1 = 6'h04;
	localparam logic [5:0] DMY_Q_3B_B0 = 6'h08;
	localparam logic [5:0] DMY_Q_4B_B1 = 6'h06;
	localparam logic [5:0] DMY_Q_4B_B0 = 6'h0a;

	// Last output slot of a byte: four on two lanes, two on four lanes
	localparam logic [1:0] SLOT_LAST_DUAL = 2'h3;
	localparam logic [1:0] SLOT_LAST_QUAD = 2'h1;

	// Byte sent when the host outruns the prefetch
	localparam logic [7:0] FNR_UNDERRUN = 8'hff;

	typedef struct packed {
		logic serial_lane_three;
		logic serial_lane_two;
		logic serial_lane_one;
		logic serial_lane_zero;
	} fnr_lanes_t;

	typedef struct packed {
		logic buf_mode;
		logic [15:0] column;
	} fnr_start_t;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} fnr_word_t;
endpackage

/* src/fnr_read_path.sv */
/*
 * Multi-lane fast-read decoder and page-buffer output path of a serial
 * NAND die. The link side runs on the host's serial clock and is held in
 * reset while chip select is high; the buffer side runs on clk and reads
 * an external page buffer with one cycle of read latency.
 */
// Summary of operation
// - Opcode 3Ch: dual-output read, 4-byte address form, data on two lanes.
// - Dual-output data drives lanes zero and one together, two bits a clock.
// - Opcode 6Bh: quad-output read, data on all four lanes.
// - Opcode 6Ch: quad-output read, 4-byte form, data on four lanes.
// - Opcode BBh: column and dummy in on two lanes, data out on two.
// - Opcode BCh: dual I/O read, 4-byte form, two-lane address and dummy.
// - Opcode EBh: address and dummy in on four lanes, data out on four.
// - Opcode ECh: quad I/O read, 4-byte form, four-lane address and dummy.
// - Buffer mode: output starts at the given column, runs to buffer end.
// - Buffer mode: after the last buffer byte the lanes go high impedance.
// - Continuous mode: output starts at buffer byte zero, column ignored.
// - Continuous mode: past buffer end, go on with next page's first byte.
// - Write-protect enable set: the four quad reads are refused.
// - Data changes on falling edges, MSB first, address steps per byte.
// - Data comes from a 2,112-byte page buffer loaded beforehand.
`timescale 1ns/100ps
`default_nettype none
module fnr_read_path
	import fnr_pkg::*;
#(
	parameter int BUF_BYTES = FNR_BUF_BYTES,
	parameter int BUF_AW = FNR_BUF_AW,
	parameter int FIFO_DEPTH = FNR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire fnr_lanes_t lanes_in,
	output fnr_lanes_t lanes_out,
	output fnr_lanes_t lanes_oe_n,
	input wire logic buffer_mode,
	input wire logic wp_enable,
	output logic [BUF_AW-1:0] buf_addr,
	input wire logic [7:0] buf_data,
	output logic page_next
);
	localparam logic [BUF_AW-1:0] LAST_ADDR = BUF_AW'(BUF_BYTES - 1);
	localparam logic [15:0] LAST_COL = 16'(BUF_BYTES - 1);

	typedef enum logic [2:0] {L_OPC, L_ADDR, L_DUMMY, L_DATA, L_IGNORE}
		fnr_lstate_t;
	typedef enum logic [1:0] {C_IDLE, C_WAIT, C_PUSH, C_END} fnr_cstate_t;

	// Link side, rising edge
	fnr_lstate_t lst_ff, nxt_lst;
	logic [5:0] cnt_ff, nxt_cnt, dmy_ff, nxt_dmy;
	logic [7:0] opc_ff, nxt_opc, opc_in;
	logic [15:0] col_ff, nxt_col;
	logic [2:0] lin_ff, nxt_lin, lout_ff, nxt_lout;
	logic bm_ff, nxt_bm, go_ff, nxt_go;
	logic [1:0] pslot_ff, nxt_pslot, slot_last;
	fnr_start_t start_ff, nxt_start;
	fnr_word_t hold_ff, nxt_hold, rd_word;
	logic pop, rd_valid;
	logic bm_s1_ff, bm_s2_ff, wp_s1_ff, wp_s2_ff;
	logic [2:0] d_lin, d_lout;
	logic [5:0] d_dmy, addr_last;
	logic d_ok, d_quad;

	// Link side, falling edge
	logic [1:0] nslot_ff, nxt_nslot;
	logic [7:0] sh_ff, nxt_sh, byte_v;
	logic cur_last_ff, nxt_cur, rel_ff, nxt_rel, last_v;
	fnr_lanes_t lo_ff, nxt_lo, oe_n_ff, nxt_oe_n;

	// Buffer side
	fnr_cstate_t cst_ff, nxt_cst;
	logic [BUF_AW-1:0] addr_ff, nxt_addr;
	logic bmc_ff, nxt_bmc, pn_ff, nxt_pn;
	logic cs_s1_ff, cs_s2_ff, go_s1_ff, go_s2_ff, go_s3_ff;
	logic wr_valid, wr_ready, is_last;
	fnr_word_t wr_word;

	// Mode bits cross into the link clock; settled well before decode
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bm_s1_ff <= 1'b0;
			bm_s2_ff <= 1'b0;
			wp_s1_ff <= 1'b0;
			wp_s2_ff <= 1'b0;
		end else begin
			bm_s1_ff <= buffer_mode;
			bm_s2_ff <= bm_s1_ff;
			wp_s1_ff <= wp_enable;
			wp_s2_ff <= wp_s1_ff;
		end
	end

	// Opcode decode: lanes in, lanes out, dummy clocks for this mode
	always_comb begin
		opc_in = {opc_ff[6:0], lanes_in.serial_lane_zero};
		d_ok = 1'b1;
		d_quad = 1'b0;
		d_lin = LANES_1;
		d_lout = LANES_4;
		d_dmy = bm_s2_ff ? DMY_S_4B_B1 : DMY_S_4B_B0;
		case (opc_in)
			OPC_DUAL_OUT_4B: begin
				d_lout = LANES_2;
			end
			OPC_QUAD_OUT: begin
				d_quad = 1'b1;
				d_dmy = bm_s2_ff ? DMY_S_3B_B1 : DMY_S_3B_B0;
			end
			OPC_QUAD_OUT_4B: begin
				d_quad = 1'b1;
			end
			OPC_DUAL_IO: begin
				d_lin = LANES_2;
				d_lout = LANES_2;
				d_dmy = bm_s2_ff ? DMY_D_3B_B1 : DMY_D_3B_B0;
			end
			OPC_DUAL_IO_4B: begin
				d_lin = LANES_2;
				d_lout = LANES_2;
				d_dmy = bm_s2_ff ? DMY_D_4B_B1 : DMY_D_4B_B0;
			end
			OPC_QUAD_IO: begin
				d_quad = 1'b1;
				d_lin = LANES_4;
				d_dmy = bm_s2_ff ? DMY_Q_3B_B1 : DMY_Q_3B_B0;
			end
			OPC_QUAD_IO_4B: begin
				d_quad = 1'b1;
				d_lin = LANES_4;
				d_dmy = bm_s2_ff ? DMY_Q_4B_B1 : DMY_Q_4B_B0;
			end
			default: begin
				d_ok = 1'b0;
			end
		endcase
	end

	// Frame sequence: opcode, column, dummy clocks, data
	always_comb begin
		nxt_lst = lst_ff;
		nxt_cnt = cnt_ff;
		nxt_opc = opc_ff;
		nxt_col = col_ff;
		nxt_lin = lin_ff;
		nxt_lout = lout_ff;
		nxt_dmy = dmy_ff;
		nxt_bm = bm_ff;
		nxt_go = go_ff;
		nxt_start = start_ff;
		nxt_pslot = pslot_ff;
		nxt_hold = hold_ff;
		pop = 1'b0;
		slot_last = (lout_ff == LANES_4) ? SLOT_LAST_QUAD : SLOT_LAST_DUAL;
		case (lin_ff)
			LANES_2: addr_last = ADDR_LAST_2;
			LANES_4: addr_last = ADDR_LAST_4;
			default: addr_last = ADDR_LAST_1;
		endcase
		case (lst_ff)
			L_OPC: begin
				nxt_opc = opc_in;
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == OPC_LAST) begin
					nxt_cnt = 6'h00;
					nxt_lin = d_lin;
					nxt_lout = d_lout;
					nxt_dmy = d_dmy;
					nxt_bm = bm_s2_ff;
					if (!d_ok || (d_quad && wp_s2_ff)) begin
						nxt_lst = L_IGNORE;
					end else begin
						nxt_lst = L_ADDR;
					end
				end
			end
			L_ADDR: begin
				case (lin_ff)
					LANES_2: nxt_col = {col_ff[13:0], lanes_in.serial_lane_one,
						lanes_in.serial_lane_zero};
					LANES_4: nxt_col = {col_ff[11:0], lanes_in};
					default: nxt_col = {col_ff[14:0], lanes_in.serial_lane_zero};
				endcase
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == addr_last) begin
					nxt_cnt = 6'h00;
					nxt_go = 1'b1;
					nxt_start = '{buf_mode: bm_ff, column: nxt_col};
					nxt_lst = L_DUMMY;
				end
			end
			L_DUMMY: begin
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == dmy_ff - 6'h01) begin
					nxt_lst = L_DATA;
					nxt_pslot = 2'h0;
					pop = 1'b1;
				end
			end
			L_DATA: begin
				nxt_pslot = pslot_ff + 2'h1;
				if (pslot_ff == slot_last) begin
					nxt_pslot = 2'h0;
					pop = 1'b1;
				end
			end
			L_IGNORE: begin
				nxt_lst = L_IGNORE;
			end
			default: begin
				nxt_lst = L_IGNORE;
			end
		endcase
		// Next byte is staged a half clock before it is shifted out
		if (pop) begin
			nxt_hold = rd_valid ? rd_word : '{last: 1'b0, data: FNR_UNDERRUN};
		end
	end

	// Chip select high ends the frame and clears the link side
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			lst_ff <= L_OPC;
			cnt_ff <= 6'h00;
			opc_ff <= 8'h00;
			col_ff <= 16'h0000;
			lin_ff <= LANES_1;
			lout_ff <= LANES_2;
			dmy_ff <= 6'h01;
			bm_ff <= 1'b0;
			go_ff <= 1'b0;
			start_ff <= '0;
			pslot_ff <= 2'h0;
			hold_ff <= '0;
		end else begin
			lst_ff <= nxt_lst;
			cnt_ff <= nxt_cnt;
			opc_ff <= nxt_opc;
			col_ff <= nxt_col;
			lin_ff <= nxt_lin;
			lout_ff <= nxt_lout;
			dmy_ff <= nxt_dmy;
			bm_ff <= nxt_bm;
			go_ff <= nxt_go;
			start_ff <= nxt_start;
			pslot_ff <= nxt_pslot;
			hold_ff <= nxt_hold;
		end
	end

	// Output shifter: MSB first, two or four bits per falling edge
	always_comb begin
		nxt_nslot = nslot_ff;
		nxt_sh = sh_ff;
		nxt_cur = cur_last_ff;
		nxt_rel = rel_ff;
		nxt_lo = '0;
		nxt_oe_n = '1;
		byte_v = (nslot_ff == 2'h0) ? hold_ff.data : sh_ff;
		last_v = (nslot_ff == 2'h0) ? hold_ff.last : cur_last_ff;
		if (lst_ff == L_DATA && !rel_ff) begin
			if (lout_ff == LANES_4) begin
				nxt_lo = byte_v[7:4];
				nxt_oe_n = '0;
				nxt_sh = {byte_v[3:0], 4'h0};
			end else begin
				nxt_lo = {2'b00, byte_v[7:6]};
				nxt_oe_n = 4'hc;
				nxt_sh = {byte_v[5:0], 2'b00};
			end
			nxt_cur = last_v;
			nxt_nslot = nslot_ff + 2'h1;
			if (nslot_ff == slot_last) begin
				nxt_nslot = 2'h0;
				nxt_rel = last_v;
			end
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			nslot_ff <= 2'h0;
			sh_ff <= 8'h00;
			cur_last_ff <= 1'b0;
			rel_ff <= 1'b0;
			lo_ff <= '0;
			oe_n_ff <= '1;
		end else begin
			nslot_ff <= nxt_nslot;
			sh_ff <= nxt_sh;
			cur_last_ff <= nxt_cur;
			rel_ff <= nxt_rel;
			lo_ff <= nxt_lo;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// Frame start and chip select cross into clk
	always_ff @(posedge clk) begin
		if (srst) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			go_s1_ff <= 1'b0;
			go_s2_ff <= 1'b0;
			go_s3_ff <= 1'b0;
		end else begin
			cs_s1_ff <= cs_n;
			cs_s2_ff <= cs_s1_ff;
			go_s1_ff <= go_ff;
			go_s2_ff <= go_s1_ff;
			go_s3_ff <= go_s2_ff;
		end
	end

	// Prefetch: walk the page buffer and feed the FIFO
	always_comb begin
		nxt_cst = cst_ff;
		nxt_addr = addr_ff;
		nxt_bmc = bmc_ff;
		nxt_pn = 1'b0;
		wr_valid = 1'b0;
		is_last = bmc_ff && (addr_ff == LAST_ADDR);
		wr_word = '{last: is_last, data: buf_data};
		case (cst_ff)
			C_IDLE: begin
				if (go_s2_ff && !go_s3_ff) begin
					nxt_bmc = start_ff.buf_mode;
					if (!start_ff.buf_mode) begin
						nxt_addr = '0;
						nxt_cst = C_WAIT;
					end else if (start_ff.column > LAST_COL) begin
						nxt_cst = C_END;
					end else begin
						nxt_addr = start_ff.column[BUF_AW-1:0];
						nxt_cst = C_WAIT;
					end
				end
			end
			C_WAIT: begin
				nxt_cst = C_PUSH;
			end
			C_PUSH: begin
				wr_valid = 1'b1;
				if (wr_ready) begin
					nxt_cst = C_WAIT;
					if (is_last) begin
						nxt_cst = C_END;
					end else if (addr_ff == LAST_ADDR) begin
						nxt_addr = '0;
						nxt_pn = 1'b1;
					end else begin
						nxt_addr = addr_ff + BUF_AW'(1);
					end
				end
			end
			C_END: begin
				nxt_cst = C_END;
			end
			default: begin
				nxt_cst = C_IDLE;
			end
		endcase
		if (cs_s2_ff) begin
			nxt_cst = C_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cst_ff <= C_IDLE;
			addr_ff <= '0;
			bmc_ff <= 1'b0;
			pn_ff <= 1'b0;
		end else begin
			cst_ff <= nxt_cst;
			addr_ff <= nxt_addr;
			bmc_ff <= nxt_bmc;
			pn_ff <= nxt_pn;
		end
	end

	// Byte FIFO between buffer clock and link clock
	fnr_async_fifo #(
		.WIDTH($bits(fnr_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wr_clk(clk),
		.wr_srst(srst | cs_s2_ff),
		.wr_valid(wr_valid),
		.wr_ready(wr_ready),
		.wr_data(wr_word),
		.rd_clk(sclk),
		.rd_arst(cs_n),
		.rd_valid(rd_valid),
		.rd_ready(pop),
		.rd_data(rd_word)
	);

	assign lanes_out = lo_ff;
	assign lanes_oe_n = oe_n_ff;
	assign buf_addr = addr_ff;
	assign page_next = pn_ff;
endmodule
`default_nettype wire

/* tb/fnr_host_model.sv */
/* Host controller model: frames one read per chip select, mode 0 clock.
 * Assumes the bench resolves lane levels from both enables. */
`timescale 1ns/100ps
`default_nettype none
module fnr_host_model
	import fnr_pkg::*;
(
	output logic sclk,
	output logic cs_n,
	output fnr_lanes_t host_val,
	output fnr_lanes_t host_en,
	input wire fnr_lanes_t lanes_in,
	input wire fnr_lanes_t lanes_oe_n
);
	logic [7:0] got_b [$];
	logic [1:0] got_s [$];

	// Clock idles low and stands still between frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_val = 4'h0;
		host_en = 4'h0;
	end

	// One clock: lanes set after the fall, sampled at the rise
	task automatic tick(input fnr_lanes_t v, input fnr_lanes_t e,
		output fnr_lanes_t s, output fnr_lanes_t so);
		host_val = v;
		host_en = e;
		#7.5;
		s = lanes_in;
		so = lanes_oe_n;
		sclk = 1'b1;
		#7.5;
		sclk = 1'b0;
	endtask

	// Whole frame; status per byte: 1 driven, 0 released, 2 mixed
	task automatic frame(input logic [7:0] opc, input logic [15:0] col,
		input int ain, input int dmy, input logic quad, input int n);
		fnr_lanes_t s, so;
		logic [7:0] b;
		logic drv, rel;
		got_b.delete();
		got_s.delete();
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--)
			tick({3'h0, opc[i]}, 4'h1, s, so);
		// Column high bits first, lane one or three highest
		for (int k = 16 / ain - 1; k >= 0; k--)
			tick(4'(col >> (k * ain)), 4'((1 << ain) - 1), s, so);
		repeat (dmy)
			tick(4'h0, 4'h0, s, so);
		for (int m = 0; m < n; m++) begin
			b = 8'h00;
			drv = 1'b1;
			rel = 1'b1;
			repeat (quad ? 2 : 4) begin
				tick(4'h0, 4'h0, s, so);
				b = quad ? {b[3:0], s} : {b[5:0], s[1:0]};
				drv &= so === (quad ? 4'h0 : 4'hc);
				rel &= so === 4'hf;
			end
			got_b.push_back(b);
			got_s.push_back(drv ? 2'h1 : (rel ? 2'h0 : 2'h2));
		end
		cs_n = 1'b1;
		host_en = 4'h0;
	endtask
endmodule
`default_nettype wire

/* tb/fnr_read_path_assertions.sv */
/* Port checker of the fast-read path: link framing, lane use, buffer port.
 * Assumes it is bound into fnr_read_path. */
`timescale 1ns/100ps
`default_nettype none
module fnr_read_path_assertions
	import fnr_pkg::*;
#(
	parameter int BUF_BYTES = FNR_BUF_BYTES,
	parameter int BUF_AW = FNR_BUF_AW,
	parameter int FIFO_DEPTH = FNR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire fnr_lanes_t lanes_in,
	input wire fnr_lanes_t lanes_out,
	input wire fnr_lanes_t lanes_oe_n,
	input wire logic buffer_mode,
	input wire logic wp_enable,
	input wire logic [BUF_AW-1:0] buf_addr,
	input wire logic [7:0] buf_data,
	input wire logic page_next
);
	logic [4:0] cnt_ff;
	logic [7:0] opc_ff;
	fnr_lanes_t ro_ff, re_ff;
	logic quad, dual;

	// Rising edges in the frame, opcode, lanes seen at each rise
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			cnt_ff <= 5'h00;
			opc_ff <= 8'h00;
			ro_ff <= 4'h0;
			re_ff <= 4'hf;
		end else begin
			ro_ff <= lanes_out;
			re_ff <= lanes_oe_n;
			if (cnt_ff != 5'h1f)
				cnt_ff <= cnt_ff + 5'h01;
			if (cnt_ff < 5'h08)
				opc_ff <= {opc_ff[6:0], lanes_in[0]};
		end
	end

	// Opcode families once all eight opcode bits are in
	assign quad = opc_ff inside {OPC_QUAD_OUT, OPC_QUAD_OUT_4B, OPC_QUAD_IO,
		OPC_QUAD_IO_4B};
	assign dual = opc_ff inside {OPC_DUAL_OUT_4B, OPC_DUAL_IO, OPC_DUAL_IO_4B};

	// Wrap pulse: continuous mode only, one clk wide
	sequence s_wrap;
		page_next && !buffer_mode ##1 !page_next;
	endsequence

	chk_idle_released: assert property (@(posedge clk)
		disable iff (srst) cs_n |-> lanes_oe_n == 4'hf)
		else $error("lanes driven outside a frame");
	chk_no_early_data: assert property (@(posedge sclk)
		disable iff (cs_n) cnt_ff <= 5'h0f |-> lanes_oe_n == 4'hf)
		else $error("data before the last dummy clock");
	chk_quad_refused: assert property (@(posedge sclk)
		disable iff (cs_n) quad && wp_enable && cnt_ff >= 5'h08
		|-> lanes_oe_n == 4'hf)
		else $error("quad read answered under write protection");
	chk_dual_lanes: assert property (@(posedge sclk)
		disable iff (cs_n) dual && cnt_ff >= 5'h08
		|-> lanes_oe_n inside {4'hf, 4'hc})
		else $error("dual read on wrong lanes");
	chk_quad_lanes: assert property (@(posedge sclk)
		disable iff (cs_n) quad && cnt_ff >= 5'h08
		|-> lanes_oe_n inside {4'hf, 4'h0})
		else $error("quad read on wrong lanes");
	chk_fall_launch: assert property (@(negedge sclk)
		disable iff (cs_n) cnt_ff != 5'h00
		|-> lanes_out == ro_ff && lanes_oe_n == re_ff)
		else $error("lanes changed after a rising edge");
	chk_addr_range: assert property (@(posedge clk)
		disable iff (srst) buf_addr < BUF_BYTES)
		else $error("buffer address past the last byte");
	chk_byte_spacing: assert property (@(posedge clk)
		disable iff (srst) $changed(buf_addr) |=> $stable(buf_addr))
		else $error("buffer address stepped twice in a row");
	chk_page_pulse: assert property (@(posedge clk)
		disable iff (srst) page_next |-> s_wrap)
		else $error("bad next-page pulse");
endmodule

bind fnr_read_path fnr_read_path_assertions #(.BUF_BYTES(BUF_BYTES),
	.BUF_AW(BUF_AW), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk(clk),
	.srst(srst), .sclk(sclk), .cs_n(cs_n), .lanes_in(lanes_in),
	.lanes_out(lanes_out), .lanes_oe_n(lanes_oe_n),
	.buffer_mode(buffer_mode), .wp_enable(wp_enable),
	.buf_addr(buf_addr), .buf_data(buf_data), .page_next(page_next));
`default_nettype wire

/* tb/nand_multi_io_fast_read_tb_top.sv */
/* Bench of the fast-read path: page buffer, lane wiring, scenarios.
 * Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module nand_multi_io_fast_read_tb_top
	import fnr_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic buffer_mode = 1'b1;
	logic wp_enable = 1'b0;
	logic flip_ff = 1'b0;
	logic sclk, cs_n, page_next;
	logic [7:0] page_ff = 8'h00;
	logic [7:0] buf_data = 8'h00;
	logic [11:0] buf_addr;
	fnr_lanes_t lanes_in, lanes_out, oe_n, h_val, h_en;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] ops [7] = '{OPC_DUAL_OUT_4B, OPC_QUAD_OUT, OPC_QUAD_OUT_4B,
		OPC_DUAL_IO, OPC_DUAL_IO_4B, OPC_QUAD_IO, OPC_QUAD_IO_4B};

	always #2.5 clk = ~clk;
	always @(posedge clk) flip_ff <= ~flip_ff;

	// Lane level: die, else host, else a level that keeps changing
	always_comb
		for (int i = 0; i < 4; i++)
			lanes_in[i] = !oe_n[i] ? lanes_out[i] : h_en[i] ? h_val[i] : flip_ff;

	function automatic logic [7:0] pat(input logic [11:0] a,
		input logic [7:0] p);
		return a[7:0] ^ {a[11:8], 4'h9} ^ (p * 8'h3b);
	endfunction

	// Page buffer, one clk of latency; every page holds other bytes
	always @(posedge clk) begin
		if (page_next)
			page_ff <= page_ff + 8'h01;
		buf_data <= pat(buf_addr, page_ff + {7'h00, page_next});
	end

	fnr_read_path dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
		.lanes_in(lanes_in), .lanes_out(lanes_out), .lanes_oe_n(oe_n),
		.buffer_mode(buffer_mode), .wp_enable(wp_enable),
		.buf_addr(buf_addr), .buf_data(buf_data), .page_next(page_next));
	fnr_host_model host (.sclk(sclk), .cs_n(cs_n), .host_val(h_val),
		.host_en(h_en), .lanes_in(lanes_in), .lanes_oe_n(oe_n));

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_flag(input logic [1:0] g, input logic [1:0] e);
		cmp_byte({6'h00, g}, {6'h00, e});
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// One frame with the lane and dummy layout of its opcode
	task automatic send(input logic [7:0] opc, input logic [15:0] col,
		input int n);
		logic [15:0] t;
		case (opc)
			OPC_DUAL_OUT_4B: t = {LANES_1, 1'b0, DMY_S_4B_B1, DMY_S_4B_B0};
			OPC_QUAD_OUT: t = {LANES_1, 1'b1, DMY_S_3B_B1, DMY_S_3B_B0};
			OPC_QUAD_OUT_4B: t = {LANES_1, 1'b1, DMY_S_4B_B1, DMY_S_4B_B0};
			OPC_DUAL_IO: t = {LANES_2, 1'b0, DMY_D_3B_B1, DMY_D_3B_B0};
			OPC_DUAL_IO_4B: t = {LANES_2, 1'b0, DMY_D_4B_B1, DMY_D_4B_B0};
			OPC_QUAD_IO: t = {LANES_4, 1'b1, DMY_Q_3B_B1, DMY_Q_3B_B0};
			default: t = {LANES_4, 1'b1, DMY_Q_4B_B1, DMY_Q_4B_B0};
		endcase
		@(posedge clk);
		#1;
		host.frame(opc, col, int'(t[15:13]),
			int'(buffer_mode ? t[11:6] : t[5:0]), t[12], n);
		repeat (8) @(posedge clk);
		#1;
	endtask

	// Every opcode in buffer mode, three bytes from its own column
	task automatic t_all_ops();
		logic [15:0] c;
		for (int k = 0; k < 7; k++) begin
			c = 16'h0031 + 16'(k) * 16'h0100;
			send(ops[k], c, 3);
			for (int j = 0; j < 3; j++) begin
				cmp_byte(host.got_b[j], pat(12'(c + j), page_ff));
				cmp_flag(host.got_s[j], 2'h1);
			end
		end
	endtask

	// Column near the end: two bytes, then lanes released
	task automatic t_buf_end();
		send(OPC_QUAD_IO, 16'h083e, 4);
		cmp_byte(host.got_b[1], pat(12'h83f, page_ff));
		for (int j = 0; j < 4; j++)
			cmp_flag(host.got_s[j], j < 2 ? 2'h1 : 2'h0);
		// Column past the buffer: no bytes fetched, underrun pattern driven
		send(OPC_QUAD_IO, 16'h0840, 2);
		cmp_byte(host.got_b[1], FNR_UNDERRUN);
		cmp_flag(host.got_s[1], 2'h1);
	endtask

	// Write protection: quad reads stay silent, dual reads answer
	task automatic t_wp();
		wp_enable = 1'b1;
		for (int k = 0; k < 7; k++) begin
			send(ops[k], 16'h0010, 2);
			cmp_flag(host.got_s[1], k inside {1, 2, 5, 6} ? 2'h0 : 2'h1);
			if (!(k inside {1, 2, 5, 6}))
				cmp_byte(host.got_b[1], pat(12'h011, page_ff));
		end
		wp_enable = 1'b0;
		// An opcode outside the set leaves the lanes released
		send(8'h5a, 16'h0010, 2);
		cmp_flag(host.got_s[1], 2'h0);
	endtask

	// Continuous mode: column ignored, runs into the next page
	task automatic t_cont();
		logic [7:0] p0;
		int a;
		p0 = page_ff;
		buffer_mode = 1'b0;
		send(OPC_QUAD_OUT, 16'h0123, 2114);
		for (int i = 0; i < 6; i++) begin
			a = i < 2 ? i : 2108 + i;
			cmp_byte(host.got_b[a], pat(12'(a % FNR_BUF_BYTES),
				p0 + 8'(a / FNR_BUF_BYTES)));
		end
		cmp_byte(page_ff - p0, 8'h01);
		// Every opcode with its continuous-mode dummy count
		for (int k = 0; k < 7; k++) begin
			send(ops[k], 16'h0200, 2);
			cmp_byte(host.got_b[1], pat(12'h001, page_ff));
			cmp_flag(host.got_s[1], 2'h1);
		end
		buffer_mode = 1'b1;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1;
		srst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		t_all_ops();
		t_buf_end();
		t_wp();
		srst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmp_byte({page_next, 3'h0, buf_addr[11:8]} | buf_addr[7:0], 8'h00);
		srst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		t_cont();
		tally_and_finish();
	end
endmodule
`default_nettype wire
